// File: hw/logic_bit_pkg.sv
// Package for the logic and bit-operation datapath.
// Assumes a 12-bit instruction word and an 8-bit data path.
package logic_bit_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int INSTR_W = 12;
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 5;

    // ------------------------------------------------------------------
    // Opcode patterns and field positions
    // ------------------------------------------------------------------
    localparam logic [5:0] OPC_AND_FILE  = 6'h05;  // Bits 11:6 = 0001 01
    localparam logic [3:0] OPC_AND_LIT   = 4'hE;   // Bits 11:8 = 1110
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;   // Bits 11:8 = 0100
    localparam logic [3:0] OPC_BIT_SET   = 4'h5;   // Bits 11:8 = 0101
    localparam int DEST_BIT   = 5;
    localparam int BITSEL_LSB = 5;
    localparam int BITSEL_W   = 3;
    localparam int OPC_MSB    = 11;  // Top bit of every opcode field
    localparam int OPC6_LSB   = 6;   // Low bit of the six-bit file-AND opcode
    localparam int OPC4_LSB   = 8;   // Low bit of the four-bit opcodes
    localparam int ADDR_LSB   = 0;
    localparam int LIT_LSB    = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ACCUM_RESET = 8'h00;
    localparam logic       ZERO_RESET  = 1'b0;

    // ------------------------------------------------------------------
    // File register write request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [4:0] addr;
        logic [7:0] data;
    } file_write_t;

    // ------------------------------------------------------------------
    // Accumulator load from the core's other instructions
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } accum_load_t;

endpackage

// File: hw/logic_and_bit_ops.sv
// Datapath for the AND and bit clear/set instructions of the core.
// Assumes the core presents one instruction and the addressed file
// register value per instruction cycle, marked by execEn, and loads the
// accumulator through accumLd for the instructions handled elsewhere.
//
// What this block does
// [RULE_01] File-AND: accumulator AND file, zero flag, one cycle
// [RULE_02] Destination bit 0 to accumulator, 1 to file
// [RULE_03] Literal-AND: accumulator AND low byte, zero flag
// [RULE_04] Literal-AND always writes accumulator, one cycle
// [RULE_05] Bit clear/set one file bit, flags untouched
`timescale 1ns/100ps

module logic_and_bit_ops
(
    // Clock and reset
    input  wire  logic                          clock,
    input  wire  logic                          nrst,
    // Instruction issue from the core
    input  wire  logic                          execEn,
    input  wire  logic [logic_bit_pkg::INSTR_W-1:0] instr,
    input  wire  logic [logic_bit_pkg::DATA_W-1:0]  fileRdData,
    // Accumulator load for instructions handled elsewhere in the core
    input  wire  logic_bit_pkg::accum_load_t    accumLd,
    // Results
    output logic [logic_bit_pkg::DATA_W-1:0]    accum,
    output logic                                zeroFlag,
    output logic_bit_pkg::file_write_t          fileWr,
    output logic                                opDone
);
    import logic_bit_pkg::*;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic       isAndFile;
    logic       isAndLit;
    logic       isBitClr;
    logic       isBitSet;
    logic       isHandled;
    logic [7:0] andFileRes;
    logic [7:0] andLitRes;
    logic [7:0] bitMask;
    logic [7:0] accum_q;
    logic       zero_q;
    file_write_t fileWr_q;
    logic       done_q;

    // Opcode matching and operand results
    assign isAndFile  = execEn && (instr[OPC_MSB:OPC6_LSB] == OPC_AND_FILE);
    assign isAndLit   = execEn && (instr[OPC_MSB:OPC4_LSB] == OPC_AND_LIT);
    assign isBitClr   = execEn && (instr[OPC_MSB:OPC4_LSB] == OPC_BIT_CLEAR);
    assign isBitSet   = execEn && (instr[OPC_MSB:OPC4_LSB] == OPC_BIT_SET);
    assign isHandled  = isAndFile | isAndLit | isBitClr | isBitSet;
    assign andFileRes = accum_q & fileRdData;                 // RULE_01
    assign andLitRes  = accum_q & instr[LIT_LSB +: DATA_W];   // RULE_03
    assign bitMask    = 8'h01 << instr[BITSEL_LSB +: BITSEL_W];

    // ------------------------------------------------------------------
    // Accumulator and zero flag
    // ------------------------------------------------------------------
    // Accumulator written by literal-AND or file-AND with dest 0.
    // A core load only lands in a cycle where no instruction is taken here:
    // one instruction per cycle, so a clash is a core fault and the op wins.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            accum_q <= ACCUM_RESET;
        end else if (isAndLit) begin
            accum_q <= andLitRes;                              // RULE_04
        end else if (isAndFile && !instr[DEST_BIT]) begin
            accum_q <= andFileRes;                             // RULE_02
        end else if (accumLd.valid && !isHandled) begin
            accum_q <= accumLd.data;
        end
    end

    // Zero flag follows both AND results; bit ops leave it alone
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            zero_q <= ZERO_RESET;
        end else if (isAndLit) begin
            zero_q <= (andLitRes == 8'h00);                    // RULE_03
        end else if (isAndFile) begin
            zero_q <= (andFileRes == 8'h00);                   // RULE_01
        end
    end

    // ------------------------------------------------------------------
    // File register write-back
    // ------------------------------------------------------------------
    // One-cycle write request for file-AND dest 1 and bit ops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fileWr_q <= '0;
        end else begin
            fileWr_q.valid <= 1'b0;
            fileWr_q.addr  <= instr[ADDR_LSB +: ADDR_W];
            fileWr_q.data  <= fileRdData;
            if (isAndFile && instr[DEST_BIT]) begin
                fileWr_q.valid <= 1'b1;                        // RULE_02
                fileWr_q.data  <= andFileRes;
            end else if (isBitClr) begin
                fileWr_q.valid <= 1'b1;                        // RULE_05
                fileWr_q.data  <= fileRdData & ~bitMask;
            end else if (isBitSet) begin
                fileWr_q.valid <= 1'b1;                        // RULE_05
                fileWr_q.data  <= fileRdData | bitMask;
            end
        end
    end

    // Completion pulse, one cycle after any handled instruction
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= isHandled;                               // RULE_04
        end
    end

    assign accum    = accum_q;
    assign zeroFlag = zero_q;
    assign fileWr   = fileWr_q;
    assign opDone   = done_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence andFileIssue;
        isAndFile;
    endsequence

    AST_ANDFILE_ZERO: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
        andFileIssue |=> (zero_q == ($past(andFileRes) == 8'h00)))
        else $error("File-AND zero flag wrong");

    AST_ANDFILE_ACC: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
        (isAndFile && !instr[DEST_BIT]) |=> (accum_q == $past(andFileRes) && !fileWr_q.valid))
        else $error("File-AND dest 0 did not load accumulator");

    AST_ANDFILE_FILE: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
        (isAndFile && instr[DEST_BIT]) |=> (fileWr_q.valid && fileWr_q.data == $past(andFileRes)
            && accum_q == $past(accum_q)))
        else $error("File-AND dest 1 did not write file");

    AST_ANDLIT_RES: assert property (@(posedge clock) disable iff (!nrst) // RULE_03
        isAndLit |=> (accum_q == ($past(accum_q) & $past(instr[7:0]))
            && zero_q == (accum_q == 8'h00)))
        else $error("Literal-AND result or zero flag wrong");

    AST_ANDLIT_NOFILE: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        isAndLit |=> (!fileWr_q.valid && opDone))
        else $error("Literal-AND wrote a file register or was late");

    AST_BITOP_DATA: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        (isBitClr || isBitSet) |=> (fileWr_q.valid
            && fileWr_q.data[$past(instr[7:5])] == $past(isBitSet)
            && zero_q == $past(zero_q) && accum_q == $past(accum_q)))
        else $error("Bit op result or flags wrong");

    AST_BITOP_ADDR: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        (isBitClr || isBitSet) |=> (fileWr_q.addr == $past(instr[4:0])
            && ((fileWr_q.data ^ $past(fileRdData)) & ~(8'h01 << $past(instr[7:5]))) == 8'h00))
        else $error("Bit op touched other bits or wrong address");

    AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        (!execEn && !accumLd.valid) |=> (!opDone && !fileWr_q.valid && $stable(accum_q)))
        else $error("State changed without an instruction");

    // Sequences for the completion, write and load checks
    sequence handledIssue;
        isHandled;
    endsequence

    sequence bitOpIssue;
        isBitClr || isBitSet;
    endsequence

    sequence fileWriteIssue;
        (isAndFile && instr[DEST_BIT]) || isBitClr || isBitSet;
    endsequence

    sequence opThenIdle;
        isHandled ##1 !execEn;
    endsequence

    sequence loadAlone;
        accumLd.valid && !isHandled;
    endsequence

    // Every taken instruction completes in the next cycle
    AST_DONE_AFTER_OP: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        handledIssue |=> opDone)
        else $error("Taken instruction did not complete in one cycle");

    // No completion pulse without a taken instruction
    AST_DONE_NEEDS_OP: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
        !isHandled |=> !opDone)
        else $error("Completion pulse without a taken instruction");

    // Completion and write pulses stand one cycle only
    AST_DONE_PULSE: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        opThenIdle |=> (!opDone && !fileWr_q.valid))
        else $error("Completion or write pulse stood too long");

    // A file-AND to the file or a bit op raises the write request
    AST_FILEWR_CAUSE: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
        fileWriteIssue |=> fileWr_q.valid)
        else $error("Missing file write request");

    // Nothing else raises the write request
    AST_FILEWR_ONLY: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        !((isAndFile && instr[DEST_BIT]) || isBitClr || isBitSet) |=> !fileWr_q.valid)
        else $error("File write request without a cause");

    // Bit ops complete and write in one cycle
    AST_BITOP_DONE: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        bitOpIssue |=> (opDone && fileWr_q.valid))
        else $error("Bit op did not complete in one cycle");

    // Zero flag moves only with the two AND ops
    AST_ZERO_HOLD: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        !(isAndFile || isAndLit) |=> $stable(zero_q))
        else $error("Zero flag changed without an AND");

    // Unmatched opcodes change nothing
    AST_REFUSED_QUIET: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
        (execEn && !isHandled && !accumLd.valid) |=> (!opDone && !fileWr_q.valid
            && $stable(accum_q) && $stable(zero_q)))
        else $error("Unmatched opcode changed state");

    // A core load with no taken op lands in the accumulator
    AST_ACC_LOAD: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        loadAlone |=> (accum_q == $past(accumLd.data)))
        else $error("Accumulator load lost");

endmodule

// File: tb/logic_and_bit_ops_bench.sv
// Self-checking bench for the AND and bit clear/set datapath.
// Assumes logic_bit_pkg and logic_and_bit_ops are compiled first.
`timescale 1ns/100ps

module logic_and_bit_ops_bench;
    import logic_bit_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus, results and counters
    // ------------------------------------------------------------------
    logic               clock      = 1'b0;
    logic               nrst       = 1'b0;
    logic               execEn     = 1'b0;
    logic [INSTR_W-1:0] instr      = 12'h000;
    logic [DATA_W-1:0]  fileRdData = 8'h00;
    accum_load_t        accumLd    = '0;
    logic [DATA_W-1:0]  accum;
    logic               zeroFlag;
    file_write_t        fileWr;
    logic               opDone;
    int                 nFail      = 0;
    int                 nCompared  = 0;
    int                 cycles     = 0;

    // Instruction clock, 100 ns period
    always #50 clock = ~clock;

    logic_and_bit_ops dut_u (.clock(clock), .nrst(nrst), .execEn(execEn), .instr(instr),
        .fileRdData(fileRdData), .accum(accum), .zeroFlag(zeroFlag), .fileWr(fileWr),
        .opDone(opDone), .accumLd(accumLd));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One instruction cycle: present inputs and any core load, let the edge land
    task automatic step(input logic en, input logic [11:0] ins, input logic [7:0] fd,
                        input logic [8:0] ld);
        execEn = en;
        instr = ins;
        fileRdData = fd;
        accumLd = ld;
        @(posedge clock);
        #1;
    endtask

    // Compare every output with its expected value; write data only with valid
    task automatic result(input logic done, input logic wv, input logic [12:0] wr,
                          input logic [7:0] acc, input logic z);
        check("opDone", {15'h0000, opDone}, {15'h0000, done});
        check("fileWr.valid", {15'h0000, fileWr.valid}, {15'h0000, wv});
        if (wv) check("fileWr", {3'h0, fileWr.addr, fileWr.data}, {3'h0, wr});
        check("accum", {8'h00, accum}, {8'h00, acc});
        check("zeroFlag", {15'h0000, zeroFlag}, {15'h0000, z});
    endtask

    // Clear then set every bit position, back to back
    task automatic testBits(input logic z);
        logic [7:0] fd;
        logic [4:0] fa;
        for (int b = 0; b < 8; b++) begin
            fd = 8'h5A ^ 8'(b * 37);
            fa = 5'(b * 5 + 3);
            step(1'b1, {OPC_BIT_CLEAR, 3'(b), fa}, fd, 9'h000);
            result(1'b1, 1'b1, {fa, fd & ~(8'h01 << b)}, 8'h00, z);
            step(1'b1, {OPC_BIT_SET, 3'(b), fa}, fd, 9'h000);
            result(1'b1, 1'b1, {fa, fd | (8'h01 << b)}, 8'h00, z);
        end
    endtask

    // Handled opcodes without execEn, then unhandled opcodes with it
    task automatic testRefused(input logic z);
        logic [11:0] ops [6] = '{12'h165, 12'hE5F, 12'h5E7, 12'h6E7, 12'h1C3, 12'hD5F};
        for (int i = 0; i < 6; i++) begin
            step(1'(i >= 3), ops[i], 8'hFF, 9'h000);
            result(1'b0, 1'b0, 13'h0000, 8'h00, z);
        end
    endtask

    // Loaded accumulator through literal-AND, file-AND to each destination, then idle
    task automatic testAnd();
        step(1'b0, 12'h000, 8'h00, {1'h1, 8'hA3});
        result(1'b0, 1'b0, 13'h0000, 8'hA3, 1'b0);
        step(1'b1, {OPC_AND_LIT, 8'h5F}, 8'hFF, 9'h000);
        result(1'b1, 1'b0, 13'h0000, 8'h03, 1'b0);
        step(1'b0, 12'h000, 8'h00, {1'h1, 8'h17});
        result(1'b0, 1'b0, 13'h0000, 8'h17, 1'b0);
        step(1'b1, {OPC_AND_FILE, 1'b1, 5'h04}, 8'hC2, 9'h000);
        result(1'b1, 1'b1, {5'h04, 8'h02}, 8'h17, 1'b0);
        step(1'b1, {OPC_AND_FILE, 1'b0, 5'h0D}, 8'hC2, 9'h000);
        result(1'b1, 1'b0, 13'h0000, 8'h02, 1'b0);
        step(1'b1, {OPC_AND_LIT, 8'hFD}, 8'h00, {1'h1, 8'h99});
        result(1'b1, 1'b0, 13'h0000, 8'h00, 1'b1);
        step(1'b0, 12'h000, 8'h00, 9'h000);
        result(1'b0, 1'b0, 13'h0000, 8'h00, 1'b1);
    endtask

    // Bit set and clear on a loaded accumulator, then a reset in mid-run
    task automatic testReset();
        step(1'b0, 12'h000, 8'h00, {1'h1, 8'hFF});
        result(1'b0, 1'b0, 13'h0000, 8'hFF, 1'b1);
        step(1'b1, {OPC_BIT_SET, 3'h7, 5'h07}, 8'h0A, 9'h000);
        result(1'b1, 1'b1, {5'h07, 8'h8A}, 8'hFF, 1'b1);
        step(1'b1, {OPC_BIT_CLEAR, 3'h7, 5'h07}, 8'hC7, 9'h000);
        result(1'b1, 1'b1, {5'h07, 8'h47}, 8'hFF, 1'b1);
        nrst = 1'b0;
        step(1'b1, {OPC_AND_LIT, 8'h00}, 8'h00, {1'h1, 8'h55});
        result(1'b0, 1'b0, 13'h0000, ACCUM_RESET, ZERO_RESET);
        nrst = 1'b1;
        step(1'b0, 12'h000, 8'h00, 9'h000);
        result(1'b0, 1'b0, 13'h0000, ACCUM_RESET, ZERO_RESET);
    endtask

    task automatic stopTest();
        if (nFail == 0 && nCompared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        #1;
        nrst = 1'b1;
        result(1'b0, 1'b0, 13'h0000, ACCUM_RESET, ZERO_RESET);
        testBits(1'b0);
        testRefused(1'b0);
        testAnd();
        testBits(1'b1);
        testRefused(1'b1);
        testReset();
        stopTest();
    end

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 200) begin
            nFail++;
            stopTest();
        end
    end
endmodule
